// [cst_defines.vh]
`ifndef CST_DEFINES_VH
`define CST_DEFINES_VH
`define CST_CLK_NS 8
`define CST_SCK_HALF_NS 64
`define CST_HALF_CYC (`CST_SCK_HALF_NS / `CST_CLK_NS)
`define CST_DIV_W 8
`define CST_CKS_SLAVE 3'h7
`define CST_BITS8_LAST 5'h07
`define CST_BITS16_LAST 5'h0F
`define CST_FIFO_DEPTH 8
`define CST_FIFO_AW 3
`define CST_ST_IDLE 2'h0
`define CST_ST_WAIT 2'h1
`define CST_ST_RUN 2'h2
`endif

// [cst_top.v]
`timescale 1ns/1ns
`default_nettype none
`include "cst_defines.vh"

module cst_fifo #(
  parameter W = 16,
  parameter D = 8,
  parameter AW = 3
)
(
  // clock and reset
  input wire clk_i,
  input wire rstn_i,
  // fill side
  input wire in_valid_i,
  input wire [W-1:0] in_data_i,
  output wire in_ready_o,
  // drain side
  output reg out_valid_o,
  output reg [W-1:0] out_data_o,
  input wire out_ready_i
);
  localparam [AW:0] FULL_CNT = D;
  localparam [AW:0] ONE_CNT = 1;
  reg [W-1:0] mem_q [0:D-1];
  reg [AW-1:0] wr_ptr_q;
  reg [AW-1:0] rd_ptr_q;
  reg [AW:0] count_q;
  wire push;
  wire pop;

  assign in_ready_o = (count_q != FULL_CNT);
  assign push = in_valid_i && in_ready_o;
  assign pop = (count_q != {(AW+1){1'b0}}) && (!out_valid_o || out_ready_i);

  always @(posedge clk_i)
  begin
    if (push)
    begin
      mem_q[wr_ptr_q] <= in_data_i;
    end
  end

  always @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      wr_ptr_q <= {AW{1'b0}};
      rd_ptr_q <= {AW{1'b0}};
      count_q <= {(AW+1){1'b0}};
      out_valid_o <= 1'b0;
      out_data_o <= {W{1'b0}};
    end
    else
    begin
      if (push)
      begin
        wr_ptr_q <= wr_ptr_q + 1'b1;
      end
      if (pop)
      begin
        rd_ptr_q <= rd_ptr_q + 1'b1;
        out_valid_o <= 1'b1;
        out_data_o <= mem_q[rd_ptr_q];
      end
      else if (out_ready_i)
      begin
        out_valid_o <= 1'b0;
      end
      if (push && !pop)
      begin
        count_q <= count_q + ONE_CNT;
      end
      else if (pop && !push)
      begin
        count_q <= count_q - ONE_CNT;
      end
    end
  end
endmodule // cst_fifo

module cst_top (
  // clock and reset
  input wire ref_clk_i,
  input wire rstn_i,
  // serial mode and clock select, one write strobe
  input wire mode_wr_i,
  input wire continuous_mode_select_i,
  input wire transmit_receive_select_i,
  input wire channel_enable_bit_i,
  input wire delayed_interrupt_select_i,
  input wire word_len16_i,
  input wire [2:0] clock_source_select_i,
  // buffer accesses
  input wire tx_buf_wr_i,
  input wire [15:0] tx_buf_data_i,
  input wire init_tx_wr_i,
  input wire [15:0] init_tx_data_i,
  input wire rx_buf_rd_i,
  // status and read data
  output reg transfer_busy_flag_o,
  output reg transfer_done_interrupt_o,
  output reg [15:0] receive_buffer_o,
  output reg [15:0] last_receive_buffer_o,
  output reg [15:0] serial_shift_register_o,
  // received word stream
  output wire rx_valid_o,
  output wire [15:0] rx_data_o,
  input wire rx_ready_i,
  // link pins
  input wire sck_i,
  output reg sck_o,
  output reg sck_oe_o,
  input wire si_i,
  output reg so_o
);
  reg auto_q;
  reg trmd_q;
  reg en_q;
  reg dly_q;
  reg wl16_q;
  reg [2:0] cks_q;
  reg [15:0] tx_buf_q;
  reg [15:0] init_tx_q;
  reg sck_s1_q;
  reg sck_s2_q;
  reg sck_s3_q;
  reg si_s1_q;
  reg si_s2_q;
  reg [`CST_DIV_W-1:0] div_q;
  reg [1:0] state_q;
  reg [1:0] req_q;
  reg [4:0] bit_q;
  reg first_q;
  reg irq_pend_q;
  reg push_q;
  wire master;
  wire tick;
  wire run;
  wire fall_ev;
  wire rise_ev;
  wire last_bit;
  wire done_ev;
  wire start_acc;
  wire reserve;
  wire cont_more;
  wire fifo_ready;
  wire [15:0] sr_shift;
  wire [15:0] tx_word;

  assign master = (cks_q != `CST_CKS_SLAVE);
  assign tick = (div_q == `CST_HALF_CYC - 1);
  assign run = (state_q == `CST_ST_RUN);
  assign fall_ev = run && (master ? (tick && sck_o) : (sck_s3_q && !sck_s2_q));
  assign rise_ev = run && (master ? (tick && !sck_o) : (!sck_s3_q && sck_s2_q));
  assign last_bit = (bit_q == (wl16_q ? `CST_BITS16_LAST : `CST_BITS8_LAST));
  assign done_ev = rise_ev && last_bit;
  // receive buffer read or transmit buffer write only; other accesses never start
  assign start_acc = en_q && (state_q == `CST_ST_IDLE)
    && (trmd_q ? tx_buf_wr_i : rx_buf_rd_i);
  // late access in the window tops the request count back up
  assign reserve = auto_q && en_q && !done_ev && (req_q == 2'h1)
    && (trmd_q ? tx_buf_wr_i : rx_buf_rd_i);
  assign cont_more = auto_q && (req_q == 2'h2);
  assign sr_shift = wl16_q ? {serial_shift_register_o[14:0], si_s2_q}
    : {8'h00, serial_shift_register_o[6:0], si_s2_q};
  assign tx_word = !trmd_q ? 16'h0000 : (first_q ? init_tx_q : tx_buf_q);

  cst_fifo #(
    .W(16),
    .D(`CST_FIFO_DEPTH),
    .AW(`CST_FIFO_AW)
  ) u_fifo (
    .clk_i(ref_clk_i),
    .rstn_i(rstn_i),
    .in_valid_i(push_q),
    .in_data_i(serial_shift_register_o),
    .in_ready_o(fifo_ready),
    .out_valid_o(rx_valid_o),
    .out_data_o(rx_data_o),
    .out_ready_i(rx_ready_i)
  );

  // pin synchronisers
  always @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      sck_s1_q <= 1'b1;
      sck_s2_q <= 1'b1;
      sck_s3_q <= 1'b1;
      si_s1_q <= 1'b0;
      si_s2_q <= 1'b0;
    end
    else
    begin
      sck_s1_q <= sck_i;
      sck_s2_q <= sck_s1_q;
      sck_s3_q <= sck_s2_q;
      si_s1_q <= si_i;
      si_s2_q <= si_s1_q;
    end
  end

  // configuration and buffer writes
  always @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      auto_q <= 1'b0;
      trmd_q <= 1'b0;
      en_q <= 1'b0;
      dly_q <= 1'b0;
      wl16_q <= 1'b0;
      cks_q <= 3'h0;
      tx_buf_q <= 16'h0000;
      init_tx_q <= 16'h0000;
      sck_oe_o <= 1'b0;
    end
    else
    begin
      if (mode_wr_i)
      begin
        auto_q <= continuous_mode_select_i;
        trmd_q <= transmit_receive_select_i;
        en_q <= channel_enable_bit_i;
        wl16_q <= word_len16_i;
        cks_q <= clock_source_select_i;
        dly_q <= delayed_interrupt_select_i
          && (clock_source_select_i != `CST_CKS_SLAVE);
      end
      if (tx_buf_wr_i)
      begin
        tx_buf_q <= wl16_q ? tx_buf_data_i : {8'h00, tx_buf_data_i[7:0]};
      end
      if (init_tx_wr_i)
      begin
        init_tx_q <= wl16_q ? init_tx_data_i : {8'h00, init_tx_data_i[7:0]};
      end
      sck_oe_o <= en_q && master;
    end
  end

  // transfer engine
  always @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      div_q <= {`CST_DIV_W{1'b0}};
      state_q <= `CST_ST_IDLE;
      req_q <= 2'h0;
      bit_q <= 5'h00;
      first_q <= 1'b0;
      irq_pend_q <= 1'b0;
      push_q <= 1'b0;
      transfer_busy_flag_o <= 1'b0;
      transfer_done_interrupt_o <= 1'b0;
      receive_buffer_o <= 16'h0000;
      last_receive_buffer_o <= 16'h0000;
      serial_shift_register_o <= 16'h0000;
      sck_o <= 1'b1;
      so_o <= 1'b0;
    end
    else
    begin
      push_q <= 1'b0;
      if (tick || state_q == `CST_ST_WAIT)
      begin
        div_q <= {`CST_DIV_W{1'b0}};
      end
      else
      begin
        div_q <= div_q + 1'b1;
      end
      // done flag: a set in the same cycle beats the mode-write clear
      if ((done_ev && !(dly_q && master)) || (irq_pend_q && tick))
      begin
        transfer_done_interrupt_o <= 1'b1;
      end
      else if (mode_wr_i)
      begin
        transfer_done_interrupt_o <= 1'b0;
      end
      if (irq_pend_q && tick)
      begin
        irq_pend_q <= 1'b0;
      end
      if (!en_q)
      begin
        serial_shift_register_o <= 16'h0000;
        state_q <= `CST_ST_IDLE;
        transfer_busy_flag_o <= 1'b0;
        req_q <= 2'h0;
        sck_o <= 1'b1;
        so_o <= 1'b0;
      end
      else
      begin
        case (state_q)
          `CST_ST_IDLE:
          begin
            if (start_acc)
            begin
              transfer_busy_flag_o <= 1'b1;
              state_q <= `CST_ST_WAIT;
              req_q <= auto_q ? 2'h2 : 2'h1;
              first_q <= auto_q && trmd_q;
            end
          end
          `CST_ST_WAIT:
          begin
            // hold the next word until the stream can take its result
            if (fifo_ready)
            begin
              state_q <= `CST_ST_RUN;
              serial_shift_register_o <= tx_word;
              so_o <= wl16_q ? tx_word[15] : tx_word[7];
              first_q <= 1'b0;
              bit_q <= 5'h00;
              sck_o <= 1'b1;
            end
          end
          `CST_ST_RUN:
          begin
            if (master && tick)
            begin
              sck_o <= !sck_o;
            end
            if (fall_ev)
            begin
              so_o <= wl16_q ? serial_shift_register_o[15] : serial_shift_register_o[7];
            end
            if (reserve)
            begin
              req_q <= 2'h2;
            end
            if (rise_ev)
            begin
              serial_shift_register_o <= sr_shift;
              bit_q <= bit_q + 5'h01;
            end
            if (done_ev)
            begin
              // the decrement wins over a coinciding late access
              req_q <= req_q - 2'h1;
              push_q <= 1'b1;
              irq_pend_q <= dly_q && master;
              // final word of a continuous run skips both receive buffers; it stays in the shift register and goes to the stream
              if (!auto_q || cont_more)
              begin
                receive_buffer_o <= sr_shift;
                last_receive_buffer_o <= sr_shift;
              end
              if (cont_more)
              begin
                state_q <= `CST_ST_WAIT;
              end
              else
              begin
                state_q <= `CST_ST_IDLE;
                transfer_busy_flag_o <= 1'b0;
              end
            end
          end
          default:
          begin
            state_q <= `CST_ST_IDLE;
          end
        endcase
      end
    end
  end
endmodule // cst_top
`default_nettype wire

// [cst_top_sva.sv]
`timescale 1ns/1ns
`default_nettype none
module cst_top_sva (
  // clock and reset
  input wire ref_clk_i,
  input wire rstn_i,
  // mode and accesses
  input wire mode_wr_i,
  input wire continuous_mode_select_i,
  input wire transmit_receive_select_i,
  input wire channel_enable_bit_i,
  input wire delayed_interrupt_select_i,
  input wire word_len16_i,
  input wire tx_buf_wr_i,
  input wire rx_buf_rd_i,
  // status and buffers
  input wire transfer_busy_flag_o,
  input wire transfer_done_interrupt_o,
  input wire [15:0] receive_buffer_o,
  input wire [15:0] serial_shift_register_o
);
  reg en_q, tr_q, au_q, w16_q;
  wire bsy = transfer_busy_flag_o;
  wire dn = transfer_done_interrupt_o;
  wire [15:0] rb = receive_buffer_o;
  wire go = en_q && (tr_q ? tx_buf_wr_i : rx_buf_rd_i);
  // shadow of mode fields
  always @(posedge ref_clk_i or negedge rstn_i)
    if (!rstn_i)
      {en_q, tr_q, au_q, w16_q} <= 4'h0;
    else if (mode_wr_i)
      {en_q, tr_q, au_q, w16_q} <= {channel_enable_bit_i, transmit_receive_select_i,
        continuous_mode_select_i, word_len16_i};
  default clocking @(posedge ref_clk_i);
  endclocking
  default disable iff (!rstn_i);
  sequence s_start;
    !bsy && go && !au_q;
  endsequence
  sequence s_word;
    bsy [*8] ##[100:900] $fell(bsy);
  endsequence
  chk_start_busy: assert property (s_start |=> s_word)
    else $error("start gave no timed busy frame");
  chk_no_start: assert property (!bsy && !go |=> !bsy)
    else $error("busy without start access");
  chk_cont_start: assert property (!bsy && go && au_q |=> bsy [*8])
    else $error("continuous start not busy");
  chk_done_busy: assert property ($fell(bsy) && en_q |-> dn)
    else $error("busy fell without done");
  chk_done_idle: assert property ($rose(dn) && !au_q |-> !bsy)
    else $error("done while still busy");
  chk_done_clear: assert property (mode_wr_i && !bsy && !delayed_interrupt_select_i |=> !dn)
    else $error("mode write kept done");
  chk_shift_clear: assert property (mode_wr_i && !channel_enable_bit_i |=> ##1 serial_shift_register_o == 16'h0000)
    else $error("shift not cleared");
  chk_byte_view: assert property ($changed(rb) && !w16_q |-> rb[15:8] == 8'h00)
    else $error("upper byte set in 8-bit");
  chk_rx_kept: assert property ($fell(bsy) && au_q && en_q |-> $stable(rb))
    else $error("receive buffer updated at run end");
endmodule // cst_top_sva
bind cst_top cst_top_sva u_chk (.ref_clk_i, .rstn_i, .mode_wr_i, .continuous_mode_select_i,
  .transmit_receive_select_i, .channel_enable_bit_i, .delayed_interrupt_select_i, .word_len16_i,
  .tx_buf_wr_i, .rx_buf_rd_i, .transfer_busy_flag_o, .transfer_done_interrupt_o, .receive_buffer_o,
  .serial_shift_register_o);
`default_nettype wire

// [cst_partner.sv]
`timescale 1ns/1ns
`default_nettype none
module cst_partner (
  // link
  input wire logic sck_i,
  input wire logic so_i,
  output logic si_o,
  // bench control
  input wire logic gen_i,
  input wire logic ld_i,
  input wire logic [15:0] word_i,
  output logic sck_o,
  output logic [15:0] got_o
);
  logic [15:0] sh_q;
  initial
  begin
    sck_o = 1'b1;
    si_o = 1'b0;
    got_o = 16'h0000;
  end
  // 160 ns clock within frames, idle high
  always #80 sck_o = gen_i ? ~sck_o : 1'b1;
  // out on falling edge, msb first
  always @(negedge sck_i or posedge ld_i)
    if (ld_i)
      sh_q <= word_i;
    else
    begin
      si_o <= sh_q[15];
      sh_q <= {sh_q[14:0], sh_q[15]};
    end
  // capture on rising edge
  always @(posedge sck_i)
    got_o <= {got_o[14:0], so_i};
endmodule // cst_partner
`default_nettype wire

// [cst_top_test.sv]
`timescale 1ns/1ns
`default_nettype none
module cst_top_test;
  logic ref_clk_i, rstn_i, mode_wr_i, continuous_mode_select_i, transmit_receive_select_i;
  logic channel_enable_bit_i, delayed_interrupt_select_i, word_len16_i, tx_buf_wr_i, init_tx_wr_i;
  logic rx_buf_rd_i, rx_ready_i, gen, ld;
  logic [2:0] clock_source_select_i;
  logic [15:0] tx_buf_data_i, init_tx_data_i, pw, lw;
  wire logic transfer_busy_flag_o, transfer_done_interrupt_o, rx_valid_o, sck_o, sck_oe_o, si_i, so_o, psck;
  wire logic [15:0] receive_buffer_o, last_receive_buffer_o, serial_shift_register_o, rx_data_o, got;
  wire logic sck_i = sck_oe_o ? sck_o : psck;
  wire logic [15:0] bsy16 = {15'h0000, transfer_busy_flag_o};
  int n_fail, cmp_count, nw, cyc, n0;
  cst_top u_dut (.ref_clk_i, .rstn_i, .mode_wr_i, .continuous_mode_select_i, .transmit_receive_select_i,
    .channel_enable_bit_i, .delayed_interrupt_select_i, .word_len16_i, .clock_source_select_i,
    .tx_buf_wr_i, .tx_buf_data_i, .init_tx_wr_i, .init_tx_data_i, .rx_buf_rd_i, .transfer_busy_flag_o,
    .transfer_done_interrupt_o, .receive_buffer_o, .last_receive_buffer_o, .serial_shift_register_o,
    .rx_valid_o, .rx_data_o, .rx_ready_i, .sck_i, .sck_o, .sck_oe_o, .si_i, .so_o);
  cst_partner u_peer (.sck_i, .so_i(so_o), .si_o(si_i), .gen_i(gen), .ld_i(ld), .word_i(pw),
    .sck_o(psck), .got_o(got));
  task summarize;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task chk(input logic [15:0] g, input logic [15:0] e);
    cmp_count++;
    if (g !== e)
    begin
      n_fail++;
      $display("BAD %0t got %h want %h", $time, g, e);
    end
  endtask
  task mode(input logic [7:0] f);
    @(negedge ref_clk_i);
    mode_wr_i = 1'b1;
    {continuous_mode_select_i, transmit_receive_select_i, channel_enable_bit_i,
      delayed_interrupt_select_i, word_len16_i, clock_source_select_i} = f;
    @(negedge ref_clk_i);
    mode_wr_i = 1'b0;
  endtask
  task acc(input logic wr, input logic [15:0] d);
    @(negedge ref_clk_i);
    tx_buf_data_i = d;
    tx_buf_wr_i = wr;
    rx_buf_rd_i = !wr;
    @(negedge ref_clk_i);
    tx_buf_wr_i = 1'b0;
    rx_buf_rd_i = 1'b0;
  endtask
  task init_wr(input logic [15:0] d);
    @(negedge ref_clk_i);
    init_tx_data_i = d;
    init_tx_wr_i = 1'b1;
    @(negedge ref_clk_i);
    init_tx_wr_i = 1'b0;
  endtask
  task pld(input logic [15:0] w);
    pw = w;
    ld = 1'b1;
    #1 ld = 1'b0;
  endtask
  task wdone;
    while (transfer_done_interrupt_o !== 1'b1)
      @(negedge ref_clk_i);
  endtask
  task t_single;
    rx_ready_i = 1'b0;
    mode(8'h60);
    pld(16'hC35A);
    acc(1'b1, 16'h00A5);
    @(negedge ref_clk_i);
    chk(bsy16, 16'h0001);
    acc(1'b1, 16'h0077);
    wdone;
    chk(receive_buffer_o, 16'h00C3);
    chk(got, 16'h00A5);
    repeat (3) @(negedge ref_clk_i);
    chk(bsy16, 16'h0000);
    rx_ready_i = 1'b1;
    repeat (4) @(negedge ref_clk_i);
    chk(lw, 16'h00C3);
    $display("end single");
  endtask
  task t_rx;
    mode(8'h28);
    pld(16'h1234);
    init_wr(16'h55AA);
    repeat (2) @(negedge ref_clk_i);
    chk(bsy16, 16'h0000);
    acc(1'b0, 16'h0000);
    wdone;
    chk(receive_buffer_o, 16'h1234);
    chk(last_receive_buffer_o, 16'h1234);
    chk(got, 16'h0000);
    $display("end receive only");
  endtask
  task t_cont(input logic t);
    mode({1'b1, t, 6'h20});
    pld(16'hC35A);
    init_wr(16'h0011);
    n0 = nw;
    acc(t, 16'h0022);
    while (nw < n0 + 1)
      @(negedge ref_clk_i);
    chk({8'h00, got[7:0]}, t ? 16'h0011 : 16'h0000);
    acc(t, 16'h0033);
    while (transfer_busy_flag_o !== 1'b0)
      @(negedge ref_clk_i);
    repeat (3) @(negedge ref_clk_i);
    if (t)
      chk(receive_buffer_o, 16'h005A);
    chk(serial_shift_register_o, 16'h00C3);
    chk(last_receive_buffer_o, 16'h005A);
    chk(lw, 16'h00C3);
    chk(16'(nw - n0), 16'h0003);
    chk(got, t ? 16'h2233 : 16'h0000);
    $display("end continuous %0d", t);
  endtask
  task t_slave;
    mode(8'h77);
    pld(16'h9600);
    acc(1'b1, 16'h0081);
    chk({15'h0000, sck_oe_o}, 16'h0000);
    gen = 1'b1;
    repeat (8) @(posedge psck);
    gen = 1'b0;
    wdone;
    chk(receive_buffer_o, 16'h0096);
    chk({8'h00, got[7:0]}, 16'h0081);
    mode(8'h40);
    @(negedge ref_clk_i);
    chk(serial_shift_register_o, 16'h0000);
    $display("end slave and disable");
  endtask
  always @(posedge ref_clk_i)
    if (rx_valid_o === 1'b1 && rx_ready_i)
    begin
      nw <= nw + 1;
      lw <= rx_data_o;
    end
  always @(posedge ref_clk_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 30000)
    begin
      n_fail++;
      summarize;
    end
  end
  initial
  begin
    ref_clk_i = 1'b0;
    forever #4 ref_clk_i = ~ref_clk_i;
  end
  initial
  begin
    {mode_wr_i, continuous_mode_select_i, transmit_receive_select_i, channel_enable_bit_i} = 4'h0;
    {delayed_interrupt_select_i, word_len16_i, tx_buf_wr_i, init_tx_wr_i, rx_buf_rd_i} = 5'h00;
    {rx_ready_i, gen, ld, clock_source_select_i} = 6'h00;
    {tx_buf_data_i, init_tx_data_i, pw} = 48'h0;
    rstn_i = 1'b0;
    repeat (20) @(negedge ref_clk_i);
    rstn_i = 1'b1;
    t_single;
    t_rx;
    t_cont(1'b1);
    t_cont(1'b0);
    t_slave;
    summarize;
  end
endmodule // cst_top_test
`default_nettype wire
